// file: sai_serial_adc.sv
/*
 * Serial control and conversion sequencer of a four-channel ten-bit
 * successive-approximation converter, stepped entirely by the shift clock pin.
 * Assumes analog channel values and the ground reference arrive as quasi-static
 * ten-bit codes that are steady around the hold instant.
 */
// What this block does
// - Sample serial input on each rising shift clock edge while selected.
// - Update serial output on each rising shift clock edge.
// - Chip select high releases serial output and strobe to high impedance.
// - Input bits are ignored while chip select is high.
// - Strobe high exactly one shift clock period before the MSB decision.
// - Shutdown input low powers the device down regardless of serial activity.
// - Shift clock moves data and steps conversion; no internal conversion clock.
// - Acquisition lasts three cycles, ending on falling edge after last control bit.
// - Single-ended routes chosen channel positive, ground reference negative.
// - Differential draws inputs only from pairs zero/one and two/three.
// - Each conversion produces a ten-bit result.
// - After chip select falls, first one bit starts the control byte.
// - Twelve decisions follow on falling edges, most significant first.
// - Each chip select falling edge drives the strobe low.
// - Unipolar results straight binary, bipolar results two's complement.
`timescale 1ns/10ps
`default_nettype none

module sai_serial_adc
	import sai_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic power_down_n,
	input wire logic [9:0] analog_channel0,
	input wire logic [9:0] analog_channel1,
	input wire logic [9:0] analog_channel2,
	input wire logic [9:0] analog_channel3,
	input wire logic [9:0] ground_reference_pin,
	output logic dout_o,
	output logic dout_oe,
	output logic conversion_strobe_o,
	output logic conversion_strobe_oe,
	output logic sample_capacitor_track,
	output logic [2:0] mux_pos_q,
	output logic [2:0] mux_neg_q,
	output logic powered_down,
	output logic [9:0] last_result_q
);

	// ------------------------------------------------------------------
	// Channel routing
	// ------------------------------------------------------------------
	function automatic logic [2:0] chan_pick(input logic [2:0] sel, input logic single, input logic want_pos);
		logic [2:0] code;
		code = SAI_MUX_CH0;
		if (single) begin
			if (!want_pos) begin
				code = SAI_MUX_GNDREF;
			end else begin
				case (sel)
					3'h1: code = SAI_MUX_CH0;
					3'h5: code = SAI_MUX_CH1;
					3'h2: code = SAI_MUX_CH2;
					3'h6: code = SAI_MUX_CH3;
					default: code = SAI_MUX_CH0;
				endcase
			end
		end else begin
			// Only the fixed pairs are reachable, polarity chosen by the top bit.
			case ({sel, want_pos})
				4'h3: code = SAI_MUX_CH0;
				4'h2: code = SAI_MUX_CH1;
				4'h5: code = SAI_MUX_CH2;
				4'h4: code = SAI_MUX_CH3;
				4'hB: code = SAI_MUX_CH1;
				4'hA: code = SAI_MUX_CH0;
				4'hD: code = SAI_MUX_CH3;
				4'hC: code = SAI_MUX_CH2;
				default: code = want_pos ? SAI_MUX_CH0 : SAI_MUX_CH1;
			endcase
		end
		return code;
	endfunction

	function automatic logic [9:0] chan_value(input logic [2:0] code, input logic [9:0] c0, input logic [9:0] c1,
			input logic [9:0] c2, input logic [9:0] c3, input logic [9:0] gref);
		logic [9:0] v;
		v = gref;
		case (code)
			SAI_MUX_CH0: v = c0;
			SAI_MUX_CH1: v = c1;
			SAI_MUX_CH2: v = c2;
			SAI_MUX_CH3: v = c3;
			default: v = gref;
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [2:0] cs_s_q;
	logic [2:0] sclk_s_q;
	logic [2:0] din_s_q;
	logic [2:0] pdn_s_q;
	logic cs_f_q;
	logic sclk_f_q;
	logic din_f_q;
	logic pdn_f_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cs_s_q <= 3'h7;
			sclk_s_q <= 3'h0;
			din_s_q <= 3'h0;
			pdn_s_q <= 3'h7;
		end else begin
			cs_s_q <= {cs_s_q[1:0], cs_n};
			sclk_s_q <= {sclk_s_q[1:0], sclk};
			din_s_q <= {din_s_q[1:0], din};
			pdn_s_q <= {pdn_s_q[1:0], power_down_n};
		end
	end

	// A change is taken once the second and third stages agree.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cs_f_q <= 1'b1;
			sclk_f_q <= 1'b0;
			din_f_q <= 1'b0;
			pdn_f_q <= 1'b1;
		end else begin
			if (cs_s_q[1] == cs_s_q[2]) begin
				cs_f_q <= cs_s_q[2];
			end
			if (sclk_s_q[1] == sclk_s_q[2]) begin
				sclk_f_q <= sclk_s_q[2];
			end
			if (din_s_q[1] == din_s_q[2]) begin
				din_f_q <= din_s_q[2];
			end
			if (pdn_s_q[1] == pdn_s_q[2]) begin
				pdn_f_q <= pdn_s_q[2];
			end
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic selected;

	assign sclk_rise = (sclk_s_q[1] == sclk_s_q[2]) && sclk_s_q[2] && !sclk_f_q;
	assign sclk_fall = (sclk_s_q[1] == sclk_s_q[2]) && !sclk_s_q[2] && sclk_f_q;
	assign cs_fall = (cs_s_q[1] == cs_s_q[2]) && !cs_s_q[2] && cs_f_q;
	assign selected = !cs_f_q;
	assign powered_down = !pdn_f_q;

	// ------------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------------
	sai_state_t state_q;
	logic [7:0] shift_q;
	logic [7:0] ctrl_q;
	logic [3:0] bit_cnt_q;
	logic [3:0] seq_q;
	logic sar_load;
	logic sar_step;
	logic sar_dec;
	logic [9:0] sar_res;
	logic [9:0] pos_val;
	logic [9:0] neg_val;
	logic [10:0] diff;
	logic [10:0] bip_code;
	logic [9:0] target;

	always_ff @(posedge sys_clk) begin
		if (sys_rst || !pdn_f_q) begin
			state_q <= SAI_ST_IDLE;
			shift_q <= SAI_CTRL_RST;
			bit_cnt_q <= SAI_CNT_RST;
			seq_q <= SAI_CNT_RST;
		end else begin
			case (state_q)
				SAI_ST_IDLE: begin
					// Leading zeros are discarded; the first one is the start bit.
					if (sclk_rise && selected && din_f_q) begin
						shift_q <= {7'h00, 1'b1};
						bit_cnt_q <= 4'h1;
						state_q <= SAI_ST_CTRL;
					end
				end
				SAI_ST_CTRL: begin
					if (sclk_rise && selected) begin
						shift_q <= {shift_q[6:0], din_f_q};
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == SAI_CTRL_LAST - 4'h1) begin
							state_q <= SAI_ST_HOLDWAIT;
						end
					end
				end
				SAI_ST_HOLDWAIT: begin
					if (sclk_fall) begin
						seq_q <= SAI_CNT_RST;
						state_q <= SAI_ST_CONV;
					end
				end
				SAI_ST_CONV: begin
					if (sclk_fall) begin
						seq_q <= seq_q + 4'h1;
						if (seq_q == SAI_DEC_LAST - 4'h1) begin
							state_q <= SAI_ST_IDLE;
						end
					end
				end
				default: state_q <= SAI_ST_IDLE;
			endcase
		end
	end

	// Track from the falling edge after the fifth control bit until hold.
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !pdn_f_q) begin
			sample_capacitor_track <= 1'b0;
		end else if (sclk_fall && state_q == SAI_ST_CTRL && bit_cnt_q >= SAI_TRACK_BIT) begin
			sample_capacitor_track <= 1'b1;
		end else if (sclk_fall && state_q == SAI_ST_HOLDWAIT) begin
			sample_capacitor_track <= 1'b0;
		end
	end

	// Selection is latched once per control byte and held through the result.
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			ctrl_q <= SAI_CTRL_RST;
			mux_pos_q <= SAI_MUX_CH0;
			mux_neg_q <= SAI_MUX_GNDREF;
		end else if (sclk_rise && selected && state_q == SAI_ST_CTRL && bit_cnt_q == SAI_CTRL_LAST - 4'h1) begin
			ctrl_q <= {shift_q[6:0], din_f_q};
			// The single-ended flag is the sixth bit taken, one place above the first mode bit.
			mux_pos_q <= chan_pick(shift_q[5:3], shift_q[1], 1'b1);
			mux_neg_q <= chan_pick(shift_q[5:3], shift_q[1], 1'b0);
		end
	end

	assign pos_val = chan_value(mux_pos_q, analog_channel0, analog_channel1, analog_channel2, analog_channel3,
		ground_reference_pin);
	assign neg_val = chan_value(mux_neg_q, analog_channel0, analog_channel1, analog_channel2, analog_channel3,
		ground_reference_pin);
	assign diff = {1'b0, pos_val} - {1'b0, neg_val};
	assign bip_code = diff + SAI_BIP_OFFSET;
	// Unipolar clamps negative differences to zero; bipolar uses offset binary inside.
	assign target = ctrl_q[SAI_CB_UNIPOLAR] ? (diff[10] ? SAI_RES_RST : diff[9:0]) : bip_code[10:1];
	assign sar_load = sclk_fall && state_q == SAI_ST_HOLDWAIT && pdn_f_q;
	assign sar_step = sclk_fall && state_q == SAI_ST_CONV && pdn_f_q;

	sai_sar_core u_sar (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.load(sar_load),
		.step(sar_step),
		.target(target),
		.decision_q(sar_dec),
		.result_q(sar_res)
	);

	// ------------------------------------------------------------------
	// Serial outputs
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !pdn_f_q || cs_fall) begin
			conversion_strobe_o <= 1'b0;
		end else if (sclk_rise) begin
			conversion_strobe_o <= (state_q == SAI_ST_CONV) && (seq_q == SAI_CNT_RST);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst || !pdn_f_q) begin
			dout_o <= 1'b0;
		end else if (sclk_rise) begin
			if (seq_q != SAI_CNT_RST && (state_q == SAI_ST_CONV || state_q == SAI_ST_IDLE)
					&& seq_q <= SAI_DEC_LAST) begin
				// The MSB is inverted in bipolar mode to give two's complement.
				dout_o <= (seq_q == 4'h1 && !ctrl_q[SAI_CB_UNIPOLAR]) ? !sar_dec : sar_dec;
			end else begin
				dout_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			last_result_q <= SAI_RES_RST;
		end else if (sclk_fall && state_q == SAI_ST_CONV && seq_q == SAI_DEC_LAST - 4'h1) begin
			last_result_q <= ctrl_q[SAI_CB_UNIPOLAR] ? sar_res : {!sar_res[9], sar_res[8:0]};
		end
	end

	assign dout_oe = selected && pdn_f_q;
	assign conversion_strobe_oe = selected && pdn_f_q;

endmodule

`default_nettype wire

// file: sai_pkg.sv
/*
 * Constants and types shared by the serial converter interface and its
 * successive-approximation core.
 * Assumes a single system clock; all serial timing is derived from sampled
 * pin edges.
 */
`default_nettype none

package sai_pkg;

	// ------------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------------
	localparam int unsigned SAI_SYNC_STAGES = 3;
	localparam int unsigned SAI_RES_W = 10;
	localparam int unsigned SAI_CTRL_BITS = 8;
	localparam int unsigned SAI_DECISIONS = 12;
	localparam int unsigned SAI_ACQ_CYCLES = 3;
	localparam logic [3:0] SAI_CTRL_LAST = 4'h8;
	localparam logic [3:0] SAI_TRACK_BIT = 4'h5;
	localparam logic [3:0] SAI_DEC_LAST = 4'hC;

	// ------------------------------------------------------------------
	// Control byte field positions
	// ------------------------------------------------------------------
	localparam int unsigned SAI_CB_START = 7;
	localparam int unsigned SAI_CB_SEL2 = 6;
	localparam int unsigned SAI_CB_SEL0 = 4;
	localparam int unsigned SAI_CB_UNIPOLAR = 3;
	localparam int unsigned SAI_CB_SINGLE = 2;
	localparam int unsigned SAI_CB_PD1 = 1;
	localparam int unsigned SAI_CB_PD0 = 0;

	// ------------------------------------------------------------------
	// Reset values and mux codes
	// ------------------------------------------------------------------
	localparam logic [7:0] SAI_CTRL_RST = 8'h00;
	localparam logic [9:0] SAI_RES_RST = 10'h000;
	localparam logic [9:0] SAI_MASK_MSB = 10'h200;
	localparam logic [3:0] SAI_CNT_RST = 4'h0;
	localparam logic [2:0] SAI_MUX_CH0 = 3'h0;
	localparam logic [2:0] SAI_MUX_CH1 = 3'h1;
	localparam logic [2:0] SAI_MUX_CH2 = 3'h2;
	localparam logic [2:0] SAI_MUX_CH3 = 3'h3;
	localparam logic [2:0] SAI_MUX_GNDREF = 3'h4;
	localparam logic [10:0] SAI_BIP_OFFSET = 11'h400;

	typedef enum logic [1:0] {
		SAI_ST_IDLE = 2'b00,
		SAI_ST_CTRL = 2'b01,
		SAI_ST_HOLDWAIT = 2'b10,
		SAI_ST_CONV = 2'b11
	} sai_state_t;

endpackage

`default_nettype wire

// file: sai_sar_core.sv
/*
 * Successive-approximation decision engine: one decision per step, MSB first.
 * Assumes load and step are one-cycle pulses from the sequencer, never together.
 */
`timescale 1ns/10ps
`default_nettype none

module sai_sar_core
	import sai_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic step,
	input wire logic [9:0] target,
	output logic decision_q,
	output logic [9:0] result_q
);

	logic [9:0] target_q;
	logic [9:0] mask_q;
	logic [9:0] trial;

	assign trial = result_q | mask_q;

	// ------------------------------------------------------------------
	// Trial and decision registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			target_q <= SAI_RES_RST;
			mask_q <= SAI_RES_RST;
			result_q <= SAI_RES_RST;
			decision_q <= 1'b0;
		end else if (load) begin
			target_q <= target;
			mask_q <= SAI_MASK_MSB;
			result_q <= SAI_RES_RST;
			decision_q <= 1'b0;
		end else if (step) begin
			// Past the last real bit the extra decisions read as zero.
			if (mask_q != SAI_RES_RST) begin
				decision_q <= (target_q >= trial);
				if (target_q >= trial) begin
					result_q <= trial;
				end
			end else begin
				decision_q <= 1'b0;
			end
			mask_q <= mask_q >> 1;
		end
	end

endmodule

`default_nettype wire

// file: sai_serial_adc_props.sv
/*
 * Port checker for the serial converter sequencer.
 * Assumes shift clock half periods of four system clocks.
 */
`timescale 1ns/10ps
`default_nettype none

module sai_serial_adc_props (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic power_down_n,
	input wire logic dout_o,
	input wire logic dout_oe,
	input wire logic conversion_strobe_o,
	input wire logic conversion_strobe_oe,
	input wire logic sample_capacitor_track,
	input wire logic [2:0] mux_pos_q,
	input wire logic [2:0] mux_neg_q,
	input wire logic powered_down
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Counts how long the sample capacitor has been tracking.
	logic [5:0] trk_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst || !sample_capacitor_track)
			trk_q <= 6'h00;
		else if (trk_q != 6'h3F)
			trk_q <= trk_q + 6'h01;
	end

	chk_oe_pair: assert property (dout_oe == conversion_strobe_oe)
		else $error("enables differ");
	chk_cs_release: assert property (cs_n [*6] |-> !dout_oe)
		else $error("driven while deselected");
	chk_pd_off: assert property (!power_down_n [*6] |-> powered_down && !dout_oe)
		else $error("shutdown not taken");
	chk_pd_idle: assert property (!power_down_n [*6] |-> !sample_capacitor_track && !conversion_strobe_o)
		else $error("sequencer active in shutdown");
	chk_strobe_width: assert property ($rose(conversion_strobe_o) |-> conversion_strobe_o [*6] ##[1:4] !conversion_strobe_o)
		else $error("strobe width wrong");
	chk_dout_step: assert property ($changed(dout_o) && !powered_down |-> $past(sclk, 4))
		else $error("output moved off the rising edge");
	chk_track_len: assert property ($fell(sample_capacitor_track) && !powered_down |-> trk_q inside {[6'h16:6'h1A]})
		else $error("acquisition length wrong");
	chk_mux_legal: assert property (mux_pos_q <= 3'h3 && (mux_neg_q == 3'h4 ||
		(mux_neg_q[2:1] == mux_pos_q[2:1] && mux_neg_q[0] != mux_pos_q[0])))
		else $error("illegal input pairing");
	chk_sel_hold: assert property ($rose(conversion_strobe_o) |-> ($stable(mux_pos_q) && $stable(mux_neg_q)) [*8])
		else $error("selection moved in conversion");
	chk_strobe_clear: assert property ($rose(dout_oe) |-> ##2 !conversion_strobe_o)
		else $error("strobe not low after select");
endmodule

`default_nettype wire

// file: sai_master_model.sv
/*
 * Serial master that frames transfers with select, shift clock and data.
 * Assumes the bench calls frame just after a system clock edge.
 */
`timescale 1ns/10ps
`default_nettype none

module sai_master_model (
	output var logic cs_n,
	output var logic sclk,
	output var logic din,
	input wire logic dout_pin
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end

	// The clock stands low outside frames and data idles inverted.
	task automatic frame(input logic sel, input logic [23:0] tx, output logic [23:0] rx);
		cs_n = !sel;
		#48;
		for (int i = 23; i >= 0; i--) begin
			din = tx[i];
			#32;
			rx[i] = dout_pin;
			sclk = 1'b1;
			#32;
			sclk = 1'b0;
		end
		#48;
		cs_n = 1'b1;
		din = !din;
	endtask
endmodule

`default_nettype wire

// file: sai_serial_adc_tb_top.sv
/*
 * Self-checking bench for the serial converter sequencer.
 * Assumes the master model and the port checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module sai_serial_adc_tb_top;
	import sai_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic power_down_n = 1'b1;
	logic [9:0] ch [4] = '{10'h2A5, 10'h3FF, 10'h100, 10'h010};
	logic [9:0] gref = 10'h020;
	logic cs_n, sclk, din, dout_o, dout_oe, conversion_strobe_o, conversion_strobe_oe;
	logic sample_capacitor_track, powered_down;
	logic [2:0] mux_pos_q, mux_neg_q;
	logic [9:0] last_result_q;
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;

	always #4 sys_clk = ~sys_clk;

	sai_serial_adc dut_u (.sys_clk, .sys_rst, .cs_n, .sclk, .din, .power_down_n,
		.analog_channel0(ch[0]), .analog_channel1(ch[1]), .analog_channel2(ch[2]),
		.analog_channel3(ch[3]), .ground_reference_pin(gref), .dout_o, .dout_oe,
		.conversion_strobe_o, .conversion_strobe_oe, .sample_capacitor_track,
		.mux_pos_q, .mux_neg_q, .powered_down, .last_result_q);

	sai_master_model mst_u (.cs_n, .sclk, .din, .dout_pin(dout_oe ? dout_o : !dout_o));

	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Two leading zeros precede the control byte, so the result lands in rx[11:2].
	task automatic conv(input logic [7:0] ctl, input logic [9:0] exp, input logic [2:0] pos, input logic [2:0] neg);
		logic [23:0] rx;
		mst_u.frame(1'b1, {2'b00, ctl, 14'h0000}, rx);
		check(rx[11:2], exp);
		check({8'h00, rx[1:0]}, 10'h000);
		check(last_result_q, exp);
		check({4'h0, mux_pos_q, mux_neg_q}, {4'h0, pos, neg});
		repeat (10) @(posedge sys_clk);
		check({9'h000, dout_oe}, 10'h000);
		#1;
	endtask

	task automatic t_single;
		logic [2:0] sel [4] = '{3'h1, 3'h5, 3'h2, 3'h6};
		for (int i = 0; i < 4; i++) begin
			conv({1'b1, sel[i], 4'hF}, ch[i] > gref ? ch[i] - gref : 10'h000, i[2:0], 3'h4);
		end
		$display("single-ended unipolar done");
	endtask

	task automatic t_diff;
		logic [2:0] sel [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
		logic [1:0] p [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
		logic [10:0] d;
		for (int i = 0; i < 4; i++) begin
			d = {1'b0, ch[p[i]]} - {1'b0, ch[p[i] ^ 2'h1]} + 11'h400;
			conv({1'b1, sel[i], 4'h3}, d[10:1] ^ 10'h200, {1'b0, p[i]}, {1'b0, p[i] ^ 2'h1});
		end
		$display("differential bipolar done");
	endtask

	task automatic t_cs_high;
		logic [23:0] rx;
		mst_u.frame(1'b0, {8'h9F, 16'h0000}, rx);
		repeat (40) @(posedge sys_clk);
		check({4'h0, mux_pos_q, mux_neg_q}, 10'h01A);
		check({9'h000, conversion_strobe_oe}, 10'h000);
		#1;
		$display("deselected bits done");
	endtask

	task automatic t_shutdown;
		logic [23:0] rx;
		logic [9:0] old;
		old = last_result_q;
		fork
			mst_u.frame(1'b1, {8'h9F, 16'h0000}, rx);
			begin
				repeat (110) @(posedge sys_clk);
				#1 power_down_n = 1'b0;
				repeat (8) @(posedge sys_clk);
				#1 check({8'h00, powered_down, dout_oe}, 10'h002);
				power_down_n = 1'b1;
			end
		join
		check(last_result_q, old);
		repeat (10) @(posedge sys_clk);
		#1;
		conv(8'hDF, ch[1] - gref, 3'h1, 3'h4);
		$display("shutdown abort done");
	endtask

	initial begin
		repeat (4) @(posedge sys_clk);
		#1 sys_rst = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1;
		t_single;
		t_diff;
		t_cs_high;
		t_shutdown;
		wrap_up;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up;
		end
	end
endmodule

bind sai_serial_adc sai_serial_adc_props props_u (.sys_clk, .sys_rst, .cs_n, .sclk, .power_down_n,
	.dout_o, .dout_oe, .conversion_strobe_o, .conversion_strobe_oe, .sample_capacitor_track,
	.mux_pos_q, .mux_neg_q, .powered_down);

`default_nettype wire
